// ### rtl/buck_gate_drive.sv
/*
  One channel's gate driver with break-before-make and prebias hold-off.
  Assumes a PWM request already phased and a run permission from the sequencer.
*/
`timescale 1ns/100ps
module buck_gate_drive (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic run,
  input wire logic prebias_hold,
  input wire logic pwm_on,
  output logic high_side_drive,
  output logic low_side_drive
);
  import buck_seq_pkg::*;

  logic armed_r;
  logic [1:0] dead_r;
  logic want_hi;

  // While prebias_hold is set, both switches stay off until the comparator first asks for an on pulse.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || !run) begin
      armed_r <= 1'b0;
    end else if (pwm_on) begin
      armed_r <= 1'b1;
    end
  end

  assign want_hi = pwm_on;

  always_ff @(posedge SYS_CLK) begin
    if (!NRST || !run) begin
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
      dead_r <= 2'h0;
    end else if (!armed_r && !pwm_on && prebias_hold) begin
      high_side_drive <= 1'b0;
      low_side_drive <= 1'b0;
      dead_r <= 2'h0;
    end else if (want_hi && !high_side_drive) begin
      low_side_drive <= 1'b0;
      if (low_side_drive || dead_r < 2'(`DEAD_CYCLES)) begin
        dead_r <= low_side_drive ? 2'h0 : dead_r + 2'h1;
      end else begin
        high_side_drive <= 1'b1;
        dead_r <= 2'h0;
      end
    end else if (!want_hi && !low_side_drive) begin
      high_side_drive <= 1'b0;
      if (high_side_drive || dead_r < 2'(`DEAD_CYCLES)) begin
        dead_r <= high_side_drive ? 2'h0 : dead_r + 2'h1;
      end else begin
        low_side_drive <= 1'b1;
        dead_r <= 2'h0;
      end
    end
  end
endmodule : buck_gate_drive

// ### rtl/buck_seq_pkg.sv
/*
  Types shared by the triple buck sequencer.
  Assumes the timing header is available on the include path.
*/
package buck_seq_pkg;
  `include "buck_seq_regs.svh"

  typedef logic [`STEP_CODE_W-1:0] step_code_t;
  typedef logic [`PHASE_W-1:0] phase_t;

  typedef enum logic [2:0] {
    CH_OFF,
    CH_SOFT_START,
    CH_RUN,
    CH_SOFT_STOP,
    CH_HICCUP
  } ch_state_e;
endpackage : buck_seq_pkg

// ### rtl/buck_seq_regs.svh
/*
  Timing counts, step layout and reset values for the triple buck sequencer.
  Assumes inclusion by the sequencer package and modules; definitions only.
*/
`ifndef BUCK_SEQ_REGS_SVH
`define BUCK_SEQ_REGS_SVH

`define SS_TOTAL_CYCLES 2048
`define SS_STEPS 64
`define SS_STEP_CYCLES (`SS_TOTAL_CYCLES / `SS_STEPS)
`define STEP_CODE_W 6
`define STEP_CODE_FULL 6'h3F
`define STEP_CODE_ZERO 6'h00
`define CL_LIMIT 4'h8
`define CL_CLEAN_CYCLES 2'h3
`define HICCUP_CYCLES 4096
`define CLK_PERIOD_NS 40
`define DEAD_TIME_NS 35
`define DEAD_CYCLES ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHASE_W 6
`define PHASE_PERIOD 6'h30
`define PHASE_THIRD 6'h10

`endif

// ### rtl/triple_buck_softstart_sequencer.sv
/*
  Digital sequencing core of a triple-output synchronous buck controller.
  Assumes analog comparators deliver flags synchronous in level to SYS_CLK,
  which runs at 48 times the switching frequency, and external gate drivers follow
  the drive outputs.
*/
// How it works
// - Nothing operates until the supply lockout flag reports supply good.
// - During lockout drivers, oscillator and logic stay in shut-down state.
// - Soft-start begins after lockout release and channel enable above turn-on.
// - Reference rises from zero in equal steps over the soft-start interval.
// - After the last step the reference holds at full value.
// - Tracking variant soft-stops a channel when its enable falls below turn-off.
// - Soft-stop lowers reference to zero in equal steps over the interval.
// - Sequencing variant keeps both switches off until first PWM on request.
// - In sequencing variant, first pulse only when ramping reference exceeds sensed feedback.
// - Dead time separates turning one switch off and the other on.
// - All channels switch at one frequency, a third of a period apart.
// - Ratiometric tracking steps all three references from one common sequence.
// - Slave hiccup on tracking makes master and other slave soft-stop.
// - Master hiccup on tracking makes both slaves soft-stop ratiometrically.
// - After hiccup timeout every channel restarts with its configured soft-start.
// - Thermal shutdown or lockout stops switching at once without ramp.
// - Tracking variant needs master enable high before any channel starts.
// - Over eight current-limit cycles forces drives low for hiccup timeout.
`timescale 1ns/100ps
module triple_buck_softstart_sequencer #(
  parameter int HICCUP_CYCLES = `HICCUP_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic TRACKING_VARIANT,
  input wire logic RATIOMETRIC,
  input wire logic SUPPLY_GOOD,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic [2:0] ENABLE_ON,
  input wire logic [2:0] ENABLE_OFF_LOW,
  input wire logic [2:0] CURRENT_LIMIT,
  input wire logic [2:0] PWM_COMPARE,
  input wire logic [2:0] REF_ABOVE_FEEDBACK,
  output logic [2:0] HIGH_SIDE_DRIVE,
  output logic [2:0] LOW_SIDE_DRIVE,
  output buck_seq_pkg::step_code_t REF_CODE_0,
  output buck_seq_pkg::step_code_t REF_CODE_1,
  output buck_seq_pkg::step_code_t REF_CODE_2,
  output logic [2:0] CLOCK_PHASE,
  output logic [2:0] HICCUP_ACTIVE
);
  import buck_seq_pkg::*;

  localparam int HW = $clog2(HICCUP_CYCLES + 1);

  // Two-stage synchronisers for every flag except PWM_COMPARE and REF_ABOVE_FEEDBACK.
  logic [10:0] sync1_r;
  logic [10:0] sync2_r;
  logic [10:0] raw_flags;
  logic supply_ok;
  logic hot;
  logic [2:0] en_on;
  logic [2:0] en_low;
  logic [2:0] cl_flag;

  assign raw_flags = {SUPPLY_GOOD, THERMAL_SHUTDOWN, ENABLE_ON, ENABLE_OFF_LOW, CURRENT_LIMIT};

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      sync1_r <= 11'h000;
      sync2_r <= 11'h000;
    end else begin
      sync1_r <= raw_flags;
      sync2_r <= sync1_r;
    end
  end

  assign supply_ok = sync2_r[10];
  assign hot = sync2_r[9];
  assign en_on = sync2_r[8:6];
  assign en_low = sync2_r[5:3];
  assign cl_flag = sync2_r[2:0];

  logic shut_down;
  assign shut_down = !supply_ok || hot;

  // Phase oscillator, held at zero during shut-down.
  phase_t phase_r;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || shut_down) begin
      phase_r <= '0;
    end else if (phase_r == `PHASE_PERIOD - 6'h01) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + 6'h01;
    end
  end

  function automatic logic in_phase(input phase_t ph, input logic [1:0] ch);
    phase_t start;
    phase_t rel;
    start = 6'(ch * `PHASE_THIRD);
    rel = (ph >= start) ? ph - start : ph + `PHASE_PERIOD - start;
    return rel < `PHASE_THIRD;
  endfunction : in_phase

  // Common step timer: one tick every thirty-two cycles, shared by all channels.
  logic [4:0] step_div_r;
  logic step_tick;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || shut_down) begin
      step_div_r <= 5'h00;
    end else begin
      step_div_r <= step_div_r + 5'h01;
    end
  end
  assign step_tick = step_div_r == 5'(`SS_STEP_CYCLES - 1);

  ch_state_e state_r [3];
  step_code_t code_r [3];
  logic [3:0] cl_count_r [3];
  logic [1:0] clean_r [3];
  logic [HW-1:0] hic_r [3];
  logic [2:0] trip;
  logic [2:0] in_hiccup;
  logic any_hiccup_done;
  logic [2:0] hic_done;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_hiccup
      assign in_hiccup[g] = state_r[g] == CH_HICCUP;
      assign trip[g] = cl_count_r[g] > `CL_LIMIT;
      assign hic_done[g] = in_hiccup[g] && hic_r[g] == HW'(HICCUP_CYCLES - 1);

      // Cumulative current-limit counter cleared by three clean cycles.
      always_ff @(posedge SYS_CLK) begin
        if (!NRST || shut_down || in_hiccup[g]) begin
          cl_count_r[g] <= 4'h0;
          clean_r[g] <= 2'h0;
        end else if (cl_flag[g]) begin
          cl_count_r[g] <= cl_count_r[g] + 4'h1;
          clean_r[g] <= 2'h0;
        end else if (clean_r[g] == `CL_CLEAN_CYCLES - 2'h1) begin
          cl_count_r[g] <= 4'h0;
          clean_r[g] <= 2'h0;
        end else begin
          clean_r[g] <= clean_r[g] + 2'h1;
        end
      end

      always_ff @(posedge SYS_CLK) begin
        if (!NRST || !in_hiccup[g]) begin
          hic_r[g] <= '0;
        end else if (!hic_done[g]) begin
          hic_r[g] <= hic_r[g] + HW'(1);
        end
      end
    end
  endgenerate

  assign any_hiccup_done = |hic_done;

  // Tracking fault coupling: a hiccup anywhere ramps the others down.
  logic [2:0] fault_stop;
  assign fault_stop[0] = TRACKING_VARIANT && (in_hiccup[1] || in_hiccup[2]);
  assign fault_stop[1] = TRACKING_VARIANT && (in_hiccup[0] || in_hiccup[2]);
  assign fault_stop[2] = TRACKING_VARIANT && (in_hiccup[0] || in_hiccup[1]);

  logic [2:0] start_ok;
  logic [2:0] stop_req;
  logic [2:0] run;
  logic [2:0] pwm_req;

  // Ratiometric channels enter their ramps in the same cycle, except that after a hiccup
  // the channel leaving it enters one cycle after the others, and step on the one
  // shared tick, so their codes stay equal without copying the master's code,
  // which would leave the slaves one step behind.

  generate
    for (g = 0; g < 3; g++) begin : g_chan
      assign start_ok[g] = TRACKING_VARIANT ? (en_on[0] && (g == 0 || RATIOMETRIC || en_on[g]))
                                            : en_on[g];
      assign stop_req[g] = (TRACKING_VARIANT && (en_low[g] || (g != 0 && en_low[0]
                           && RATIOMETRIC))) || fault_stop[g];

      always_ff @(posedge SYS_CLK) begin
        if (!NRST || shut_down) begin
          state_r[g] <= CH_OFF;
          code_r[g] <= `STEP_CODE_ZERO;
        end else begin
          case (state_r[g])
            CH_OFF: begin
              if (start_ok[g] && !(|in_hiccup)) begin
                state_r[g] <= CH_SOFT_START;
                code_r[g] <= `STEP_CODE_ZERO;
              end
            end
            CH_SOFT_START: begin
              if (trip[g]) begin
                state_r[g] <= CH_HICCUP;
              end else if (stop_req[g] || !start_ok[g] && !TRACKING_VARIANT) begin
                state_r[g] <= TRACKING_VARIANT ? CH_SOFT_STOP : CH_OFF;
              end else if (step_tick) begin
                code_r[g] <= code_r[g] + 6'h01;
                if (code_r[g] == `STEP_CODE_FULL - 6'h01) begin
                  state_r[g] <= CH_RUN;
                end
              end
            end
            CH_RUN: begin
              code_r[g] <= `STEP_CODE_FULL;
              if (trip[g]) begin
                state_r[g] <= CH_HICCUP;
              end else if (stop_req[g]) begin
                state_r[g] <= CH_SOFT_STOP;
              end else if (!start_ok[g] && !TRACKING_VARIANT) begin
                state_r[g] <= CH_OFF;
              end
            end
            CH_SOFT_STOP: begin
              if (trip[g]) begin
                state_r[g] <= CH_HICCUP;
              end else if (step_tick) begin
                if (code_r[g] != `STEP_CODE_ZERO) begin
                  code_r[g] <= code_r[g] - 6'h01;
                end
                if (code_r[g] == `STEP_CODE_ZERO) begin
                  state_r[g] <= CH_OFF;
                end
              end
            end
            CH_HICCUP: begin
              code_r[g] <= `STEP_CODE_ZERO;
              if (hic_done[g]) begin
                state_r[g] <= CH_OFF;
              end
            end
            default: begin
              state_r[g] <= CH_OFF;
            end
          endcase
          if (any_hiccup_done && state_r[g] == CH_OFF && start_ok[g]) begin
            state_r[g] <= CH_SOFT_START;
            code_r[g] <= `STEP_CODE_ZERO;
          end
        end
      end

      assign run[g] = state_r[g] == CH_SOFT_START || state_r[g] == CH_RUN
                      || state_r[g] == CH_SOFT_STOP;
      // The PWM request is gated to the channel's third of the period.
      assign pwm_req[g] = PWM_COMPARE[g] && in_phase(phase_r, 2'(g))
                          && (TRACKING_VARIANT || REF_ABOVE_FEEDBACK[g]
                          || state_r[g] != CH_SOFT_START);

      buck_gate_drive u_drive (
        .SYS_CLK(SYS_CLK),
        .NRST(NRST),
        .run(run[g] && !shut_down),
        .prebias_hold(!TRACKING_VARIANT && state_r[g] == CH_SOFT_START),
        .pwm_on(pwm_req[g]),
        .high_side_drive(HIGH_SIDE_DRIVE[g]),
        .low_side_drive(LOW_SIDE_DRIVE[g])
      );
    end
  endgenerate

  // Reference codes and status leave through flip-flops.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      REF_CODE_0 <= `STEP_CODE_ZERO;
      REF_CODE_1 <= `STEP_CODE_ZERO;
      REF_CODE_2 <= `STEP_CODE_ZERO;
      HICCUP_ACTIVE <= 3'h0;
      CLOCK_PHASE <= 3'h0;
    end else begin
      REF_CODE_0 <= code_r[0];
      REF_CODE_1 <= code_r[1];
      REF_CODE_2 <= code_r[2];
      HICCUP_ACTIVE <= in_hiccup;
      CLOCK_PHASE <= shut_down ? 3'h0 : {in_phase(phase_r, 2'h2), in_phase(phase_r, 2'h1),
                                         in_phase(phase_r, 2'h0)};
    end
  end
endmodule : triple_buck_softstart_sequencer

// ### verification/buck_far_side.sv
/*
  Far-side model: PWM and feedback comparators for the three channels.
  Assumes a fixed prebiased feedback level and the registered phase slots.
*/
`timescale 1ns/100ps
module buck_far_side
  import buck_seq_pkg::*;
#(
  parameter step_code_t PREBIAS = 6'h08
) (
  input wire logic [2:0] clock_phase,
  input wire step_code_t ref_code_0,
  input wire step_code_t ref_code_1,
  input wire step_code_t ref_code_2,
  output logic [2:0] pwm_compare,
  output logic [2:0] ref_above_feedback
);
  // The output stays prebiased, so no pulse is wanted until the ramp passes it.
  assign ref_above_feedback = {ref_code_2 > PREBIAS, ref_code_1 > PREBIAS, ref_code_0 > PREBIAS};
  assign pwm_compare = ref_above_feedback & clock_phase;
endmodule : buck_far_side

// ### verification/tb_triple_buck_softstart_sequencer.sv
/*
  Self-checking bench for the sequencer with a far-side comparator model.
  Assumes the checker is bound in and a short hiccup timeout for run length.
*/
`timescale 1ns/100ps
module tb_triple_buck_softstart_sequencer;
  import buck_seq_pkg::*;
  logic SYS_CLK = 1'b0, NRST = 1'b0, TRACKING_VARIANT = 1'b0, RATIOMETRIC = 1'b0;
  logic SUPPLY_GOOD = 1'b0, THERMAL_SHUTDOWN = 1'b0;
  logic [2:0] ENABLE_ON = 3'b000, ENABLE_OFF_LOW = 3'b000, CURRENT_LIMIT = 3'b000;
  logic [2:0] PWM_COMPARE, REF_ABOVE_FEEDBACK, HIGH_SIDE_DRIVE, LOW_SIDE_DRIVE;
  logic [2:0] CLOCK_PHASE, HICCUP_ACTIVE;
  step_code_t REF_CODE_0, REF_CODE_1, REF_CODE_2;
  int mismatches = 0, n_tests = 0, cyc = 0, n;
  logic sw;
  always #20 SYS_CLK = ~SYS_CLK;
  triple_buck_softstart_sequencer #(.HICCUP_CYCLES(64)) dut (.SYS_CLK(SYS_CLK), .NRST(NRST),
    .TRACKING_VARIANT(TRACKING_VARIANT), .RATIOMETRIC(RATIOMETRIC), .SUPPLY_GOOD(SUPPLY_GOOD),
    .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .ENABLE_ON(ENABLE_ON), .ENABLE_OFF_LOW(ENABLE_OFF_LOW),
    .CURRENT_LIMIT(CURRENT_LIMIT), .PWM_COMPARE(PWM_COMPARE), .REF_ABOVE_FEEDBACK(REF_ABOVE_FEEDBACK),
    .HIGH_SIDE_DRIVE(HIGH_SIDE_DRIVE), .LOW_SIDE_DRIVE(LOW_SIDE_DRIVE), .REF_CODE_0(REF_CODE_0),
    .REF_CODE_1(REF_CODE_1), .REF_CODE_2(REF_CODE_2), .CLOCK_PHASE(CLOCK_PHASE),
    .HICCUP_ACTIVE(HICCUP_ACTIVE));
  buck_far_side far (.clock_phase(CLOCK_PHASE), .ref_code_0(REF_CODE_0), .ref_code_1(REF_CODE_1),
    .ref_code_2(REF_CODE_2), .pwm_compare(PWM_COMPARE), .ref_above_feedback(REF_ABOVE_FEEDBACK));
  task cmp_code(input step_code_t got, input step_code_t exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_code
  task cmp_bits(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_bits
  task stop_test();
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // Waits on the falling edge so registered outputs have settled.
  task wait_ref(input int ch, input step_code_t v);
    sw = 1'b0;
    for (n = 0; n < 3000 && (ch == 0 ? REF_CODE_0 : REF_CODE_1) !== v; n++) begin
      @(negedge SYS_CLK);
      sw = sw | HIGH_SIDE_DRIVE[0] | LOW_SIDE_DRIVE[0];
    end
  endtask : wait_ref
  task do_reset(input logic trk, input logic rat);
    @(posedge SYS_CLK);
    NRST <= 1'b0;
    TRACKING_VARIANT <= trk;
    RATIOMETRIC <= rat;
    {SUPPLY_GOOD, THERMAL_SHUTDOWN, ENABLE_ON, ENABLE_OFF_LOW} <= 8'h00;
    repeat (5) @(posedge SYS_CLK);
    NRST <= 1'b1;
  endtask : do_reset
  task t_lockout();
    @(posedge SYS_CLK) ENABLE_ON <= 3'b111;
    repeat (200) @(negedge SYS_CLK);
    cmp_bits(HIGH_SIDE_DRIVE | LOW_SIDE_DRIVE, 3'b000);
    cmp_code(REF_CODE_0, 6'h00);
  endtask : t_lockout
  task t_softstart();
    @(posedge SYS_CLK) SUPPLY_GOOD <= 1'b1;
    wait_ref(0, 6'h08);
    cmp_bits({2'b00, sw}, 3'b000);
    wait_ref(0, 6'h0A);
    wait_ref(0, 6'h0B);
    cmp_code(step_code_t'(n), 6'h20);
    wait_ref(0, 6'h3F);
    repeat (100) @(negedge SYS_CLK);
    cmp_code(REF_CODE_0, 6'h3F);
    cmp_code(REF_CODE_1, 6'h3F);
    sw = 1'b0;
    repeat (48) @(negedge SYS_CLK) sw = sw | HIGH_SIDE_DRIVE[0];
    cmp_bits({2'b00, sw}, 3'b001);
  endtask : t_softstart
  task t_hiccup();
    @(posedge SYS_CLK) CURRENT_LIMIT <= 3'b001;
    repeat (12) @(posedge SYS_CLK);
    CURRENT_LIMIT <= 3'b000;
    repeat (2) @(negedge SYS_CLK);
    cmp_bits(HICCUP_ACTIVE, 3'b001);
    cmp_bits({HIGH_SIDE_DRIVE[0], LOW_SIDE_DRIVE[0], 1'b0}, 3'b000);
    repeat (65) @(negedge SYS_CLK);
    cmp_bits(HICCUP_ACTIVE, 3'b000);
    cmp_code(REF_CODE_0, 6'h00);
    wait_ref(0, 6'h3F);
    cmp_code(REF_CODE_0, 6'h3F);
  endtask : t_hiccup
  task t_softstop();
    do_reset(1'b1, 1'b0);
    @(posedge SYS_CLK) {SUPPLY_GOOD, ENABLE_ON} <= 4'hF;
    wait_ref(1, 6'h3F);
    @(posedge SYS_CLK) {ENABLE_ON[1], ENABLE_OFF_LOW[1]} <= 2'b01;
    wait_ref(1, 6'h3D);
    wait_ref(1, 6'h3C);
    cmp_code(step_code_t'(n), 6'h20);
    wait_ref(1, 6'h00);
    cmp_code(REF_CODE_1, 6'h00);
    cmp_code(REF_CODE_0, 6'h3F);
  endtask : t_softstop
  task t_ratio_thermal();
    do_reset(1'b1, 1'b1);
    @(posedge SYS_CLK) {SUPPLY_GOOD, ENABLE_ON} <= 4'h9;
    wait_ref(0, 6'h0A);
    cmp_code(REF_CODE_1, 6'h0A);
    cmp_code(REF_CODE_2, 6'h0A);
    @(posedge SYS_CLK) CURRENT_LIMIT <= 3'b001;
    repeat (12) @(posedge SYS_CLK);
    CURRENT_LIMIT <= 3'b000;
    wait_ref(1, 6'h00);
    cmp_bits({2'b00, n > 200}, 3'b001);
    cmp_code(REF_CODE_2, 6'h00);
    @(posedge SYS_CLK) THERMAL_SHUTDOWN <= 1'b1;
    repeat (5) @(negedge SYS_CLK);
    cmp_bits(HIGH_SIDE_DRIVE | LOW_SIDE_DRIVE, 3'b000);
  endtask : t_ratio_thermal
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    do_reset(1'b0, 1'b0);
    t_lockout();
    t_softstart();
    @(posedge SYS_CLK) ENABLE_ON <= 3'b111;
    wait_ref(0, 6'h3F);
    t_hiccup();
    t_softstop();
    t_ratio_thermal();
    stop_test();
  end
endmodule : tb_triple_buck_softstart_sequencer

// ### verification/triple_buck_softstart_sequencer_checker.sv
/*
  Port checks for the sequencer: lockout, drive safety, phasing, ramp and hiccup.
  Assumes binding to the sequencer top with its hiccup length handed on.
*/
`timescale 1ns/100ps
module seq_port_checker
  import buck_seq_pkg::*;
#(
  parameter int HICCUP_CYCLES = 4096
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SUPPLY_GOOD,
  input wire logic THERMAL_SHUTDOWN,
  input wire logic [2:0] ENABLE_ON,
  input wire logic [2:0] HIGH_SIDE_DRIVE,
  input wire logic [2:0] LOW_SIDE_DRIVE,
  input wire step_code_t REF_CODE_0,
  input wire logic [2:0] CLOCK_PHASE,
  input wire logic [2:0] HICCUP_ACTIVE
);
  default clocking @(posedge SYS_CLK); endclocking
  // Thermal shutdown stops the oscillator at once, so pending phase attempts are dropped.
  default disable iff (!NRST || THERMAL_SHUTDOWN);
  step_code_t prev_r;
  logic [7:0] gap_r;
  logic [12:0] hic_r;
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      prev_r <= 6'h00;
      gap_r <= 8'h00;
    end else begin
      prev_r <= REF_CODE_0;
      gap_r <= (REF_CODE_0 != prev_r) ? 8'h00 : gap_r + {7'h00, gap_r != 8'hFF};
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!NRST || !HICCUP_ACTIVE[0]) hic_r <= 13'h0000;
    else hic_r <= hic_r + 13'h0001;
  end
  sequence s_to_slot1;
    ##16 CLOCK_PHASE == 3'b010;
  endsequence
  sequence s_to_slot2;
    ##16 CLOCK_PHASE == 3'b100;
  endsequence
  a_lockout_drives_off: assert property (!SUPPLY_GOOD [*5] |-> (HIGH_SIDE_DRIVE | LOW_SIDE_DRIVE) == 3'b000)
    else $error("drives active during lockout");
  a_no_shoot_through: assert property ((HIGH_SIDE_DRIVE & LOW_SIDE_DRIVE) == 3'b000)
    else $error("both switches on");
  a_dead_time_gap: assert property ((HIGH_SIDE_DRIVE & $past(LOW_SIDE_DRIVE)) == 3'b000 && (LOW_SIDE_DRIVE & $past(HIGH_SIDE_DRIVE)) == 3'b000)
    else $error("no dead cycle between switches");
  a_phase_thirds: assert property ($rose(CLOCK_PHASE[0]) |-> s_to_slot1 ##0 s_to_slot2)
    else $error("phase slots not a third apart");
  a_step_size: assert property (REF_CODE_0 != prev_r |-> REF_CODE_0 == 6'h00 || REF_CODE_0 == step_code_t'(prev_r + 6'h01) || REF_CODE_0 == step_code_t'(prev_r - 6'h01))
    else $error("reference jumped by more than one step");
  a_step_spacing: assert property (REF_CODE_0 != prev_r && REF_CODE_0 != 6'h00 && prev_r != 6'h00 && prev_r != 6'h3F |-> gap_r == 8'h1F)
    else $error("reference step spacing wrong");
  a_start_gated: assert property (REF_CODE_0 == 6'h01 && prev_r == 6'h00 |-> $past(SUPPLY_GOOD, 4) && $past(ENABLE_ON[0], 4))
    else $error("ramp started without supply and enable");
  a_hiccup_drives_low: assert property (HICCUP_ACTIVE[0] && $past(HICCUP_ACTIVE[0]) |-> !HIGH_SIDE_DRIVE[0] && !LOW_SIDE_DRIVE[0])
    else $error("drive during hiccup");
  a_hiccup_length: assert property ($fell(HICCUP_ACTIVE[0]) |-> hic_r == 13'(HICCUP_CYCLES))
    else $error("hiccup timeout length wrong");
endmodule : seq_port_checker
bind triple_buck_softstart_sequencer seq_port_checker #(.HICCUP_CYCLES(HICCUP_CYCLES)) u_chk (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .SUPPLY_GOOD(SUPPLY_GOOD),
  .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .ENABLE_ON(ENABLE_ON),
  .HIGH_SIDE_DRIVE(HIGH_SIDE_DRIVE), .LOW_SIDE_DRIVE(LOW_SIDE_DRIVE), .REF_CODE_0(REF_CODE_0),
  .CLOCK_PHASE(CLOCK_PHASE), .HICCUP_ACTIVE(HICCUP_ACTIVE));
